// [design/fbmc_host.sv]
`include "fbmc_map.svh"

// Operation
// - write: strobe and select low, gate high
// - wait full access time after standby
// - no read before reset recovery time
// - reissue jobs interrupted by reset; the host only flags them on resetInterrupted
// - elevated id: A6 low, A1:A0 pick
// - group address bits give protect code
// - read: select and gate low, strobe high
module fbmc_host
    import fbmc_pkg::*;
#(
    parameter logic [15:0] RP_CYC    = 16'(`FBMC_RP_CYC),   // reset low
    parameter logic [15:0] RH_CYC    = 16'(`FBMC_RH_CYC),   // recovery
    parameter logic [15:0] READY_CYC = 16'(`FBMC_READY_CYC) // busy wait
)
(
    input  wire logic        sys_clk,           // system clock
    input  wire logic        rst_n,             // async reset, active low
    input  wire logic        reqValid,          // request offered
    output logic             reqReady,          // request taken when high
    input  wire fbmc_op_t    reqOp,             // operation
    input  wire logic [20:0] reqAddr,           // byte address
    input  wire logic [7:0]  reqData,           // write data
    output logic             rspValid,          // one-cycle answer
    output logic [7:0]       rspData,           // read data or status
    output logic             rspProtected,      // protect bit of answer
    output logic             rspTimeout,        // busy never cleared
    output logic             deviceBusy,        // synced busy level
    output logic             resetInterrupted,  // reset hit a busy job
    output logic [4:0]       sectorIndex,       // sector of last address
    output logic             flashCeN,          // chip select, low
    output logic             flashOeN,          // output gate, low
    output logic             flashWeN,          // write strobe, low
    output logic             flashResetN,       // hardware reset, low
    output logic [20:0]      flashAddr,         // address pins
    output logic [7:0]       dataLinesOut,      // data pins, out value
    output logic             dataLinesOe,       // host drives data pins
    input  wire logic [7:0]  dataLinesIn,       // data pins, in value
    input  wire logic        readyBusyIn,       // ready_busy_out pin
    output logic             elevatedIdVoltage  // raise id address line
);

    localparam logic [15:0] RD_CYC = 16'(`FBMC_ACC_CYC + `FBMC_SYNC_CYC);
    localparam logic [15:0] WP_CYC = 16'(`FBMC_WP_CYC);
    fbmc_state_t state_r;    // sequencer state
    fbmc_state_t state_nxt;  // next sequencer state
    logic        accept;     // request taken this cycle
    logic        tmrLoad;    // restart the timer
    logic [15:0] tmrVal;     // value for the timer
    logic        tmrDone;    // timed phase over
    logic [7:0]  dataMeta_r; // data synchroniser, first stage
    logic [7:0]  dataSync_r; // data synchroniser, second stage
    logic        rbMeta_r;   // busy synchroniser, first stage
    logic        rbSync_r;   // busy synchroniser, second stage
    logic        isProt_r;   // current read is a protect check

    assign reqReady   = (state_r == ST_IDLE);
    assign accept     = reqValid && reqReady;
    assign deviceBusy = !rbSync_r;

    fbmc_timer u_timer
    (
        .sys_clk (sys_clk), .rst_n (rst_n), .load (tmrLoad),
        .loadVal (tmrVal), .done (tmrDone)
    );

    // both pins come from the device's own timing, so two stages each
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {dataMeta_r, dataSync_r, rbMeta_r, rbSync_r} <= 18'h00003;
        else
        begin
            {dataSync_r, dataMeta_r} <= {dataMeta_r, dataLinesIn};
            {rbSync_r, rbMeta_r}     <= {rbMeta_r, readyBusyIn};
        end
    end

    // next state and timer loads
    always_comb
    begin
        state_nxt = state_r;
        tmrLoad   = 1'b0;
        tmrVal    = 16'h0000;
        unique case (state_r)
            ST_IDLE:
                if (accept)
                begin
                    unique case (reqOp)
                        OP_WRITE: state_nxt = ST_WR_SETUP;
                        OP_RESET:
                        begin
                            state_nxt = ST_RST_LOW;
                            tmrLoad   = 1'b1;
                            tmrVal    = RP_CYC;
                        end
                        default:
                        begin
                            // access time plus the synchroniser lag
                            state_nxt = ST_READ;
                            tmrLoad   = 1'b1;
                            tmrVal    = RD_CYC;
                        end
                    endcase
                end
            ST_READ:
                if (tmrDone)
                    state_nxt = ST_IDLE;
            ST_WR_SETUP:
            begin
                state_nxt = ST_WR_PULSE;
                tmrLoad   = 1'b1;
                tmrVal    = WP_CYC;
            end
            ST_WR_PULSE:
                if (tmrDone)
                    state_nxt = ST_WR_HOLD;
            ST_WR_HOLD: state_nxt = ST_IDLE;
            ST_RST_LOW:
                if (tmrDone)
                begin
                    state_nxt = ST_RST_REC;
                    tmrLoad   = 1'b1;
                    tmrVal    = RH_CYC;
                end
            ST_RST_REC:
                if (tmrDone)
                begin
                    state_nxt = ST_RST_WAIT;
                    tmrLoad   = 1'b1;
                    tmrVal    = READY_CYC;
                end
            ST_RST_WAIT:
                // a busy device holds the line low until it is done
                if (rbSync_r || tmrDone)
                    state_nxt = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // control strobes decoded from the next state, so pins are glitch free
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {flashCeN, flashOeN, flashWeN, flashResetN, dataLinesOe} <= 5'h1e;
        else
        begin
            // idle leaves select high, so the part sits in standby
            flashCeN    <= !(state_nxt inside {ST_READ, ST_WR_SETUP,
                                               ST_WR_PULSE, ST_WR_HOLD});
            flashOeN    <= (state_nxt != ST_READ);
            flashWeN    <= (state_nxt != ST_WR_PULSE);
            flashResetN <= (state_nxt != ST_RST_LOW);
            // only drive the bus while the device output is gated off
            dataLinesOe <= (state_nxt inside {ST_WR_SETUP,
                                              ST_WR_PULSE, ST_WR_HOLD});
        end
    end

    // address, write data and id voltage latched with the request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {flashAddr, dataLinesOut, elevatedIdVoltage, isProt_r} <= 31'h0;
        else if (accept)
        begin
            flashAddr         <= reqAddr;
            dataLinesOut      <= reqData;
            elevatedIdVoltage <= (reqOp == OP_ID) || (reqOp == OP_PROT);
            isProt_r          <= (reqOp == OP_PROT);
            if (reqOp == OP_ID)
            begin
                flashAddr[`FBMC_ID_A6] <= 1'b0;
                flashAddr[1:0]         <= reqAddr[0] ? `FBMC_ID_DEVICE
                                                     : `FBMC_ID_MANUF;
            end
            else if (reqOp == OP_PROT)
            begin
                // group bits pass through, the rest selects the check
                flashAddr[`FBMC_GROUP_LO-1:0] <= 18'h00000;
                flashAddr[1:0]                <= `FBMC_ID_PROT;
            end
        end
        else if (state_r == ST_IDLE)
            elevatedIdVoltage <= 1'b0;
    end

    assign sectorIndex = flashAddr[`FBMC_SECT_HI:`FBMC_SECT_LO];
    // answers: read data on the last read cycle, end of a reset wait
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {rspValid, rspData, rspProtected, rspTimeout} <= 11'h000;
        else
        begin
            rspValid <= 1'b0;
            if (state_r == ST_READ && tmrDone)
            begin
                rspValid     <= 1'b1;
                rspData      <= dataSync_r;
                rspProtected <= isProt_r &&
                                dataSync_r[`FBMC_PROT_BIT];
                rspTimeout   <= 1'b0;
            end
            else if (state_r == ST_RST_WAIT && state_nxt == ST_IDLE)
            begin
                rspValid     <= 1'b1;
                rspData      <= 8'h00;
                rspProtected <= 1'b0;
                rspTimeout   <= !rbSync_r;
            end
        end
    end

    // software must redo a job that a reset cut short; the flag says so
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            resetInterrupted <= 1'b0;
        else if (accept && reqOp == OP_RESET && !rbSync_r)
            resetInterrupted <= 1'b1;
        else if (accept && reqOp == OP_WRITE)
            resetInterrupted <= 1'b0;
    end
    // helper counters watched only by the checks below
    logic [15:0] gateLowCnt; // cycles the gate has been low
    logic [15:0] rstLowCnt;  // cycles reset has been low
    logic [7:0]  sinceRst;   // cycles since reset went high, saturating
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {gateLowCnt, rstLowCnt, sinceRst} <= 40'h00000000ff;
        else
        begin
            gateLowCnt <= flashOeN ? 16'h0000 : gateLowCnt + 16'h0001;
            rstLowCnt  <= flashResetN ? 16'h0000 : rstLowCnt + 16'h0001;
            if (!flashResetN)
                sinceRst <= 8'h00;
            else if (sinceRst != 8'hff)
                sinceRst <= sinceRst + 8'h01;
        end
    end

    AST_WRITE_LEVELS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !flashWeN |-> !flashCeN && flashOeN && dataLinesOe)
        else $error("write strobe low with bad select or gate");
    AST_READ_LEVELS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !flashOeN |-> !flashCeN && flashWeN && !dataLinesOe)
        else $error("gate low with bad select or strobe");
    AST_ACCESS_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_READ && tmrDone |-> gateLowCnt >= RD_CYC)
        else $error("read data sampled before access time");
    AST_RESET_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(flashResetN) |-> $past(rstLowCnt) >= RP_CYC)
        else $error("reset pulse shorter than minimum");
    AST_RESET_RECOVERY: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $fell(flashOeN) |-> sinceRst >= 8'(RH_CYC))
        else $error("read started inside reset recovery");
    AST_FLOAT_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataLinesOe |-> flashOeN ##1 flashOeN)
        else $error("host drives data while device gate open");
    AST_ID_ADDRESS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        elevatedIdVoltage && !flashOeN |->
            !flashAddr[`FBMC_ID_A6] && flashAddr[1:0] != 2'h3)
        else $error("elevated id read with bad address");
    AST_BUSY_SAMPLED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_RST_WAIT && state_nxt == ST_IDLE |->
            ##1 rspValid && rspTimeout == !$past(rbSync_r))
        else $error("reset wait left without busy sample");

endmodule : fbmc_host

// [design/fbmc_map.svh]
`ifndef FBMC_MAP_SVH
`define FBMC_MAP_SVH

// system clock period
`define FBMC_CLK_NS      20
// chip-select access time, also the wake-up time out of standby
`define FBMC_ACC_NS      70
// write strobe low width
`define FBMC_WP_NS       35
// least reset pulse width (reset_pulse_min)
`define FBMC_RP_NS       500
// reset high to first read (reset_to_read_time)
`define FBMC_RH_NS       50
// longest internal reset completion while an embedded job runs
`define FBMC_READY_NS    20000

// cycle counts, rounded up because the host waits at least this long
`define FBMC_ACC_CYC   ((`FBMC_ACC_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_WP_CYC    ((`FBMC_WP_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_RP_CYC    ((`FBMC_RP_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_RH_CYC    ((`FBMC_RH_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
`define FBMC_READY_CYC ((`FBMC_READY_NS + `FBMC_CLK_NS - 1) / `FBMC_CLK_NS)
// stages of the pin synchronisers
`define FBMC_SYNC_CYC    2

// address field positions
`define FBMC_SECT_HI     20
`define FBMC_SECT_LO     16
`define FBMC_GROUP_LO    18
`define FBMC_ID_A6       6
// code in the low address pair for each identifier read
`define FBMC_ID_MANUF    2'h0
`define FBMC_ID_DEVICE   2'h1
`define FBMC_ID_PROT     2'h2
// data bit that reports a protected group
`define FBMC_PROT_BIT    0

`endif

// [design/fbmc_pkg.sv]
package fbmc_pkg;

    // controller sequencer states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_READ     = 4'h1,
        ST_WR_SETUP = 4'h2,
        ST_WR_PULSE = 4'h3,
        ST_WR_HOLD  = 4'h4,
        ST_RST_LOW  = 4'h5,
        ST_RST_REC  = 4'h6,
        ST_RST_WAIT = 4'h7
    } fbmc_state_t;

    // user-side operations
    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_WRITE = 3'h1,
        OP_RESET = 3'h2,
        OP_ID    = 3'h3,
        OP_PROT  = 3'h4
    } fbmc_op_t;

endpackage : fbmc_pkg

// [design/fbmc_timer.sv]
// down counter shared by every timed phase of the sequencer
module fbmc_timer
(
    input  wire logic        sys_clk, // system clock
    input  wire logic        rst_n,   // async reset, active low
    input  wire logic        load,    // load a new count
    input  wire logic [15:0] loadVal, // count to load
    output logic             done     // count has reached zero
);

    logic [15:0] count_r; // remaining cycles

    // load wins over the decrement so a phase can restart at once
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= 16'h0000;
        else if (load)
            count_r <= loadVal;
        else if (count_r != 16'h0000)
            count_r <= count_r - 16'h0001;
    end

    assign done = (count_r == 16'h0000);

endmodule : fbmc_timer

// [verification/fbmc_flash_model.sv]
// behavioural flash part: no clock, driven by pin edges and levels
module fbmc_flash_model
#(
    parameter int         ACC_NS   = 70,    // select to valid data
    parameter int         RP_NS    = 80,    // least reset pulse
    parameter int         RH_NS    = 30,    // reset high to first read
    parameter int         BUSY_NS  = 2000,  // erase job length
    parameter int         RBUSY_NS = 200,   // reset of a running job
    parameter logic [7:0] MANUF    = 8'h5c, // arbitrary value
    parameter logic [7:0] DEVICE   = 8'h3e, // arbitrary value
    parameter logic [7:0] PMASK    = 8'ha5, // protected groups
    parameter logic [7:0] STATUS   = 8'h4c  // value read while busy
)
(
    input  wire logic        ceN,       // chip select
    input  wire logic        oeN,       // output gate
    input  wire logic        weN,       // write strobe
    input  wire logic        resetN,    // hardware reset
    input  wire logic [20:0] addr,      // address pins
    input  wire logic [7:0]  hostData,  // host data value
    input  wire logic        hostOe,    // host drives data
    input  wire logic        idHigh,    // elevated id level applied
    input  wire logic        stuckBusy, // bench holds busy low
    output logic [7:0]       busLevel,  // resolved data lines
    output logic             readyBusy, // ready_busy_out pin
    output int               violations // host broke a pin rule
);
    realtime busyEnd = 0.0;     // end of running job
    realtime rstFall = 0.0;     // last reset fall
    realtime rstRise = -1000.0; // last reset rise
    logic    idMode  = 1'b0;    // id command mode
    logic    ceOk    = 1'b0;    // access time met
    logic    pulsed  = 1'b0;    // a reset pulse was seen
    logic    devDrive;          // device drives data
    logic [7:0] devVal;         // value device offers

    initial violations = 0;
    initial busLevel = 8'h00;

    // identifier decode on the low address pair
    function automatic logic [7:0] ident(input logic [20:0] a);
        case (a[1:0])
            2'h0: return MANUF;
            2'h1: return DEVICE;
            2'h2: return {7'h00, PMASK[a[20:18]]};
            default: return 8'h00;
        endcase
    endfunction : ident

    // polled so the job keeps running while deselected
    always #5 readyBusy = !(stuckBusy || $realtime < busyEnd);

    // data is junk until the full access time has passed
    always @(negedge ceN)
    begin
        ceOk = 1'b0;
        #ACC_NS;
        ceOk = !ceN;
    end
    always @(posedge ceN) ceOk = 1'b0;

    // output select
    always_comb
    begin
        devDrive = !ceN && !oeN && weN && resetN;
        if (!readyBusy)
            devVal = STATUS;
        else if (idMode || (idHigh && !addr[6]))
            devVal = ident(addr);
        else
            devVal = addr[7:0] ^ {3'h0, addr[20:16]};
    end

    // a floated bus never shows the last value
    always @(hostOe, hostData, devDrive, devVal, ceOk)
        if (hostOe)
            busLevel = hostData;
        else if (devDrive && ceOk)
            busLevel = devVal;
        else
            busLevel = ~busLevel;

    // commands latch on the rising strobe
    always @(posedge weN)
        if (!ceN && resetN)
        begin
            if (oeN !== 1'b1)
                violations++;
            if (readyBusy)
                case (hostData)
                    8'h90: idMode = 1'b1;
                    8'hf0: idMode = 1'b0;
                    8'h30: busyEnd = $realtime + BUSY_NS;
                    default: ;
                endcase
        end

    // reset aborts; a running job keeps busy low a while
    always @(negedge resetN)
    begin
        pulsed = 1'b1;
        rstFall = $realtime;
        idMode = 1'b0;
        busyEnd = ($realtime < busyEnd) ? $realtime + RBUSY_NS
                                        : 0.0;
    end

    always @(posedge resetN)
    begin
        if (pulsed && $realtime - rstFall < RP_NS)
            violations++;
        rstRise = $realtime;
    end

    always @(negedge oeN)
        if (!ceN && (weN !== 1'b1 || $realtime - rstRise < RH_NS))
            violations++;
endmodule : fbmc_flash_model

// [verification/test_flash_bus_mode_control.sv]
module test_flash_bus_mode_control
    import fbmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] MANUF  = 8'h5c; // arbitrary value
    localparam logic [7:0] DEVICE = 8'h3e; // arbitrary value
    localparam logic [7:0] PMASK  = 8'ha5; // protected groups
    localparam logic [7:0] STATUS = 8'h4c; // busy read value

    logic sys_clk, rst_n, reqValid, reqReady, rspValid, rspProtected;
    logic rspTimeout, deviceBusy, resetInterrupted, flashCeN, flashOeN;
    logic flashWeN, flashResetN, dataLinesOe, readyBusy, stuckBusy;
    logic elevatedIdVoltage, sawElev;
    fbmc_op_t    reqOp;
    logic [20:0] reqAddr, flashAddr, a;
    logic [7:0]  reqData, rspData, dataLinesOut, busLevel;
    logic [4:0]  sectorIndex;
    int          errors, testsRun, violations;
    int unsigned seedv;

    fbmc_host #(.RP_CYC(16'h4), .RH_CYC(16'h1), .READY_CYC(16'h14)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid),
        .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
        .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
        .rspProtected(rspProtected), .rspTimeout(rspTimeout),
        .deviceBusy(deviceBusy), .resetInterrupted(resetInterrupted),
        .sectorIndex(sectorIndex), .flashCeN(flashCeN),
        .flashOeN(flashOeN), .flashWeN(flashWeN),
        .flashResetN(flashResetN), .flashAddr(flashAddr),
        .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
        .dataLinesIn(busLevel), .readyBusyIn(readyBusy),
        .elevatedIdVoltage(elevatedIdVoltage));

    fbmc_flash_model #(.MANUF(MANUF), .DEVICE(DEVICE), .PMASK(PMASK),
        .STATUS(STATUS)) flash (
        .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
        .resetN(flashResetN), .addr(flashAddr), .hostData(dataLinesOut),
        .hostOe(dataLinesOe), .idHigh(elevatedIdVoltage),
        .stuckBusy(stuckBusy), .busLevel(busLevel),
        .readyBusy(readyBusy), .violations(violations));

    // free-running system clock
    always #10 sys_clk = ~sys_clk;

    // note any cycle with the elevated id level raised
    always @(negedge sys_clk)
        if (elevatedIdVoltage === 1'b1)
            sawElev = 1'b1;

    task automatic end_of_test;
        if (errors == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // expected array content
    function automatic logic [7:0] pat(input logic [20:0] x);
        return x[7:0] ^ {3'h0, x[20:16]};
    endfunction : pat

    function automatic logic probe(input int k);
        case (k)
            0: return reqReady;
            1: return rspValid;
            default: return deviceBusy;
        endcase
    endfunction : probe

    // bounded wait, checked at falling edges where outputs are settled
    task automatic await(input int k, input logic v);
        int n;
        n = 0;
        while (probe(k) !== v)
        begin
            n++;
            if (n > 3000)
            begin
                errors++;
                end_of_test();
            end
            @(negedge sys_clk);
        end
    endtask : await

    // one request; every operation but a write waits for its answer
    task automatic req(input fbmc_op_t op, input logic [20:0] ad,
                       input logic [7:0] d);
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqAddr <= ad;
        reqData <= d;
        sawElev = 1'b0;
        @(negedge sys_clk);
        await(0, 1'b1);
        @(posedge sys_clk);
        reqValid <= 1'b0;
        if (op != OP_WRITE)
            await(1, 1'b1);
    endtask : req

    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqOp = OP_READ;
        reqAddr = 21'h0;
        reqData = 8'h00;
        stuckBusy = 1'b0;
        errors = 0;
        testsRun = 0;
        seedv = $urandom(16038);
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        check("idlePins", {flashCeN, flashOeN, flashWeN, flashResetN,
              dataLinesOe}, 5'h1e);
        // array reads from power-up, boundary and random addresses
        for (int i = 0; i < 14; i++)
        begin
            a = (i == 0) ? 21'h0 : (i == 1) ? 21'h1fffff : 21'($urandom);
            req(OP_READ, a, 8'h00);
            check("readData", rspData, pat(a));
            check("sector", sectorIndex, a[20:16]);
            check("deselect", {flashCeN, flashOeN}, 2'h3);
        end
        // elevated level identification
        req(OP_ID, 21'h0, 8'h00);
        check("manuf", rspData, MANUF);
        check("elevated", sawElev, 1'b1);
        req(OP_ID, 21'h1, 8'h00);
        check("device", rspData, DEVICE);
        // every group, random low bits must be cleared by the host
        for (int g = 0; g < 8; g++)
        begin
            req(OP_PROT, {3'(g), 18'($urandom)}, 8'h00);
            check("protCode", rspData, {7'h00, PMASK[g]});
            check("protFlag", rspProtected, PMASK[g]);
            check("protAddr", flashAddr, {3'(g), 18'h00002});
        end
        // in-system identification by command
        req(OP_WRITE, 21'h555, 8'h90);
        req(OP_READ, 21'h0, 8'h00);
        check("cmdManuf", rspData, MANUF);
        check("noElev", sawElev, 1'b0);
        req(OP_READ, 21'h1, 8'h00);
        check("cmdDevice", rspData, DEVICE);
        req(OP_WRITE, 21'h0, 8'hf0);
        // erase, status read, job survives deselect
        req(OP_WRITE, 21'h0a0000, 8'h30);
        await(2, 1'b1);
        req(OP_READ, 21'h0a0012, 8'h00);
        check("status", rspData, STATUS);
        check("stillBusy", deviceBusy, 1'b1);
        await(2, 1'b0);
        req(OP_READ, 21'h0a0012, 8'h00);
        check("afterJob", rspData, pat(21'h0a0012));
        // reset in mid-job leaves id mode and aborts
        req(OP_WRITE, 21'h555, 8'h90);
        req(OP_WRITE, 21'h0, 8'h30);
        await(2, 1'b1);
        req(OP_RESET, 21'h0, 8'h00);
        check("busyRstTo", rspTimeout, 1'b0);
        check("rstPin", flashResetN, 1'b1);
        check("interrupted", resetInterrupted, 1'b1);
        req(OP_READ, 21'h1, 8'h00);
        check("rstArray", rspData, pat(21'h1));
        // reissue the aborted job
        req(OP_WRITE, 21'h0, 8'h30);
        @(negedge sys_clk);
        check("reissued", resetInterrupted, 1'b0);
        await(2, 1'b1);
        await(2, 1'b0);
        // reset while idle
        req(OP_RESET, 21'h0, 8'h00);
        check("idleRstTo", rspTimeout, 1'b0);
        check("idleInt", resetInterrupted, 1'b0);
        // busy never clears
        @(posedge sys_clk);
        stuckBusy <= 1'b1;
        await(2, 1'b1);
        req(OP_RESET, 21'h0, 8'h00);
        check("stuckTo", rspTimeout, 1'b1);
        @(posedge sys_clk);
        stuckBusy <= 1'b0;
        await(2, 1'b0);
        check("hostPins", violations, 0);
        end_of_test();
    end
endmodule : test_flash_bus_mode_control
